// >>> verilog/dxi_ddr2_init.sv
// ddr2 device side: mode register loads and init sequence tracking
// Functional notes
// - each mode register holds until reloaded; loads never touch the array.
// - next load register 2 via ba 10; only high-temp bit may be set (the tracker accepts any value).
// - then load register 3 via ba 11, all zero (the tracker accepts any value).
// - then load register 1, a0 low enabling the dll.
// - then load main register with a8 high; dll locks in 200 clocks.
// - then load main register with a8 low, no second dll reset.
// - device ready once 200 clocks have passed since the dll reset load and the ocd exit load to register 1 is done.
// - a10 high precharges all; bank bits select the mode register.
`include "dxi_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module dxi_ddr2_init (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire dxi_pkg::dxi_cmd_bus_t cmd_bus,
  output var dxi_pkg::dxi_regs_t regs_q,
  output logic dll_locked_q,
  output logic ready_q,
  output logic banks_idle_q,
  output logic term_on_q,
  output logic seq_err_q,
  output logic [3:0] init_state_q
);
  import dxi_pkg::*;

  dxi_state_t state_q;
  dxi_state_t state_d;
  logic [`DXI_CNT_W-1:0] dll_cnt_q;
  logic [1:0] ref_cnt_q;
  logic cke_q;

  // command decode
  wire dxi_cmd_t cmd = cmd_bus.cs_b ? DXI_C_NOP :
    dxi_cmd_t'({1'b0, cmd_bus.ras_b, cmd_bus.cas_b, cmd_bus.we_b});
  wire [1:0] sel = cmd_bus.ba[1:0];
  wire [12:0] code = cmd_bus.addr[12:0];
  wire is_lm = cmd_bus.cke && (cmd == DXI_C_LM);
  wire is_ref = cmd_bus.cke && (cmd == DXI_C_REF);
  wire is_pre_all = cmd_bus.cke && (cmd == DXI_C_PRE) &&
    cmd_bus.addr[`DXI_BIT_AP];
  wire is_act = cmd_bus.cke && (cmd == DXI_C_ACT);
  wire lm_mr = is_lm && (sel == `DXI_BA_MR);
  wire lm_emr1 = is_lm && (sel == `DXI_BA_EMR1);
  wire lm_emr2 = is_lm && (sel == `DXI_BA_EMR2);
  wire lm_emr3 = is_lm && (sel == `DXI_BA_EMR3);
  wire dll_reset = lm_mr && code[`DXI_BIT_DLL_RESET];
  wire ocd_bits_all = code[`DXI_OCD_HI:`DXI_OCD_LO] == `DXI_OCD_ALL;
  wire ocd_bits_none = code[`DXI_OCD_HI:`DXI_OCD_LO] == 3'h0;
  wire busy = (cmd != DXI_C_NOP) && cmd_bus.cke;
  wire rtt_on = regs_q.emr1[`DXI_BIT_RTT0] | regs_q.emr1[`DXI_BIT_RTT1];
  wire cnt_zero = dll_cnt_q == '0;
  wire ref_enough = ref_cnt_q >= `DXI_MIN_REF;

  // expected next step and the step it leads to
  logic step_ok;
  always_comb
  begin
    state_d = state_q;
    step_ok = 1'b1;
    unique case (state_q)
      DXI_S_PWR:
        if (cmd_bus.cke && !cke_q)
          state_d = DXI_S_PRE1;
      DXI_S_PRE1:
      begin
        step_ok = !busy || is_pre_all;
        if (is_pre_all)
          state_d = DXI_S_EMR2;
      end
      DXI_S_EMR2:
      begin
        step_ok = !busy || lm_emr2;
        if (lm_emr2)
          state_d = DXI_S_EMR3;
      end
      DXI_S_EMR3:
      begin
        step_ok = !busy || lm_emr3;
        if (lm_emr3)
          state_d = DXI_S_DLLEN;
      end
      DXI_S_DLLEN:
      begin
        step_ok = !busy || (lm_emr1 && !code[`DXI_BIT_DLL_DIS]);
        if (lm_emr1 && !code[`DXI_BIT_DLL_DIS])
          state_d = DXI_S_DLLRST;
      end
      DXI_S_DLLRST:
      begin
        step_ok = !busy || dll_reset;
        if (dll_reset)
          state_d = DXI_S_PRE2;
      end
      DXI_S_PRE2:
      begin
        step_ok = !busy || is_pre_all;
        if (is_pre_all)
          state_d = DXI_S_REF;
      end
      DXI_S_REF:
      begin
        step_ok = !busy || is_ref ||
          (lm_mr && ref_enough && !code[`DXI_BIT_DLL_RESET]);
        if (lm_mr && ref_enough && !code[`DXI_BIT_DLL_RESET])
          state_d = DXI_S_OCD1;
      end
      DXI_S_MR:
        state_d = DXI_S_OCD1;
      DXI_S_OCD1:
      begin
        step_ok = !busy || (lm_emr1 && ocd_bits_all);
        if (lm_emr1 && ocd_bits_all)
          state_d = DXI_S_OCD2;
      end
      DXI_S_OCD2:
      begin
        step_ok = !busy || (lm_emr1 && ocd_bits_none);
        if (lm_emr1 && ocd_bits_none)
          state_d = DXI_S_DONE;
      end
      DXI_S_DONE:
        state_d = DXI_S_DONE;
      default:
        state_d = DXI_S_PWR;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= DXI_S_PWR;
      cke_q <= 1'b0;
      seq_err_q <= 1'b0;
    end
    else if (ce)
    begin
      state_q <= state_d;
      cke_q <= cmd_bus.cke;
      if (!step_ok || (state_q != DXI_S_PWR && state_q != DXI_S_DONE &&
          !cmd_bus.cke))
        seq_err_q <= 1'b1;
    end
  end

  // mode registers hold until reloaded; array untouched by loads
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      regs_q <= {4{`DXI_MR_RST}};
    else if (ce)
    begin
      if (lm_mr)
        regs_q.mr <= code;
      if (lm_emr1)
        regs_q.emr1 <= code;
      if (lm_emr2)
        regs_q.emr2 <= code;
      if (lm_emr3)
        regs_q.emr3 <= code;
    end
  end

  // dll lock counter and readiness
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dll_cnt_q <= '0;
      dll_locked_q <= 1'b0;
      ready_q <= 1'b0;
      ref_cnt_q <= 2'h0;
    end
    else if (ce)
    begin
      if (dll_reset)
        dll_cnt_q <= `DXI_DLL_LOCK_CYC - 8'h01;
      else if (!cnt_zero)
        dll_cnt_q <= dll_cnt_q - 8'h01;
      dll_locked_q <= !dll_reset && cnt_zero && !dll_locked_q ?
        (state_q >= DXI_S_PRE2) : (dll_locked_q && !dll_reset) ||
        (!dll_reset && dll_cnt_q == 8'h01);
      ready_q <= !dll_reset && (state_d == DXI_S_DONE) &&
        (cnt_zero || dll_cnt_q == 8'h01);
      if (state_q == DXI_S_PRE2)
        ref_cnt_q <= 2'h0;
      else if (is_ref && !ref_enough)
        ref_cnt_q <= ref_cnt_q + 2'h1;
    end
  end

  // bank state and termination
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      banks_idle_q <= 1'b1;
      term_on_q <= 1'b0;
    end
    else if (ce)
    begin
      if (is_act)
        banks_idle_q <= 1'b0;
      else if (is_pre_all)
        banks_idle_q <= 1'b1;
      term_on_q <= cmd_bus.odt && cmd_bus.cke && rtt_on;
    end
  end

  assign init_state_q = state_q;

  sequence s_dll_rst;
    ce && dll_reset;
  endsequence

  a_ready_delay: assert property (@(posedge clk) disable iff (!rst_b)
    s_dll_rst ##1 (ce && !dll_reset)[*8] |-> !ready_q)
    else $error("ready raised too soon after dll reset");
  a_lock_time: assert property (@(posedge clk) disable iff (!rst_b)
    ce && dll_reset |=> !dll_locked_q)
    else $error("dll lock not cleared by dll reset");
  a_emr2_load: assert property (@(posedge clk) disable iff (!rst_b)
    ce && lm_emr2 |=> regs_q.emr2 == $past(code))
    else $error("register 2 not loaded");
  a_emr3_load: assert property (@(posedge clk) disable iff (!rst_b)
    ce && lm_emr3 |=> regs_q.emr3 == $past(code))
    else $error("register 3 not loaded");
  a_emr1_load: assert property (@(posedge clk) disable iff (!rst_b)
    ce && lm_emr1 |=> regs_q.emr1 == $past(code))
    else $error("register 1 not loaded");
  a_reg_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !is_lm || !ce |=> $stable(regs_q))
    else $error("mode register changed without a load");
  a_mr_final: assert property (@(posedge clk) disable iff (!rst_b)
    ce && state_q == DXI_S_REF && lm_mr && ref_enough &&
    !code[`DXI_BIT_DLL_RESET] |=> state_q == DXI_S_OCD1)
    else $error("final main register load not tracked");
  a_pre_all: assert property (@(posedge clk) disable iff (!rst_b)
    ce && is_pre_all && !is_act |=> banks_idle_q)
    else $error("precharge all did not idle banks");
  a_cnt_run: assert property (@(posedge clk) disable iff (!rst_b)
    ce && dll_reset |=> dll_cnt_q == (`DXI_DLL_LOCK_CYC - 8'h01))
    else $error("lock counter not loaded with 199");
endmodule // dxi_ddr2_init
`default_nettype wire

// >>> verilog/dxi_consts.svh
// constants for the ddr2 mode register and init tracker
`ifndef DXI_CONSTS_SVH
`define DXI_CONSTS_SVH
`define DXI_ADDR_W 16
`define DXI_BA_W 3
`define DXI_MR_W 13
`define DXI_MR_RST 13'h0000
`define DXI_BA_MR 2'h0
`define DXI_BA_EMR1 2'h1
`define DXI_BA_EMR2 2'h2
`define DXI_BA_EMR3 2'h3
`define DXI_BIT_DLL_RESET 8
`define DXI_BIT_DLL_DIS 0
`define DXI_BIT_HTR 7
`define DXI_BIT_RTT0 2
`define DXI_BIT_RTT1 6
`define DXI_BIT_AP 10
`define DXI_OCD_LO 7
`define DXI_OCD_HI 9
`define DXI_OCD_ALL 3'h7
`define DXI_DLL_LOCK_CYC 8'hC8
`define DXI_CNT_W 8
`define DXI_MIN_REF 2'h2
`endif

// >>> verilog/dxi_pkg.sv
// types for the ddr2 mode register and init tracker
package dxi_pkg;
  typedef struct packed {
    logic cke;
    logic cs_b;
    logic ras_b;
    logic cas_b;
    logic we_b;
    logic odt;
    logic [2:0] ba;
    logic [15:0] addr;
  } dxi_cmd_bus_t;

  typedef enum logic [3:0] {
    DXI_C_LM = 4'h0,
    DXI_C_REF = 4'h1,
    DXI_C_PRE = 4'h2,
    DXI_C_ACT = 4'h3,
    DXI_C_WR = 4'h4,
    DXI_C_RD = 4'h5,
    DXI_C_BST = 4'h6,
    DXI_C_NOP = 4'h7
  } dxi_cmd_t;

  typedef enum logic [3:0] {
    DXI_S_PWR = 4'h0,
    DXI_S_PRE1 = 4'h1,
    DXI_S_EMR2 = 4'h2,
    DXI_S_EMR3 = 4'h3,
    DXI_S_DLLEN = 4'h4,
    DXI_S_DLLRST = 4'h5,
    DXI_S_PRE2 = 4'h6,
    DXI_S_REF = 4'h7,
    DXI_S_MR = 4'h8,
    DXI_S_OCD1 = 4'h9,
    DXI_S_OCD2 = 4'hA,
    DXI_S_DONE = 4'hB
  } dxi_state_t;

  typedef struct packed {
    logic [12:0] mr;
    logic [12:0] emr1;
    logic [12:0] emr2;
    logic [12:0] emr3;
  } dxi_regs_t;
endpackage

// >>> tb/dxi_ctrl_model.sv
// controller-side model driving the ddr2 command bus
`timescale 1ns/1ps
`default_nettype none
module dxi_ctrl_model (
  input wire logic clk,
  output var dxi_pkg::dxi_cmd_bus_t cmd_bus
);
  import dxi_pkg::*;
  initial cmd_bus = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 3'h0, 16'h0000};
  // one command, then nop gap with a changing address
  task automatic cmd(input logic [3:0] code, input logic [1:0] bank,
    input logic [12:0] a);
    @(negedge clk);
    {cmd_bus.cs_b, cmd_bus.ras_b, cmd_bus.cas_b, cmd_bus.we_b} = code;
    cmd_bus.ba = {1'b0, bank};
    cmd_bus.addr = {3'h0, a};
    @(negedge clk);
    {cmd_bus.cs_b, cmd_bus.ras_b, cmd_bus.cas_b, cmd_bus.we_b} = 4'h7;
    cmd_bus.addr = {3'h0, ~a};
    @(negedge clk);
  endtask
  task automatic power_up;
    cmd_bus.cke = 1'b0;
    cmd_bus.cs_b = 1'b1;
    cmd_bus.odt = 1'b0;
    repeat (5000) @(negedge clk);
    cmd_bus.cke = 1'b1;
    cmd_bus.cs_b = 1'b0;
    repeat (10) @(negedge clk);
  endtask
  task automatic odt_set(input logic v);
    @(negedge clk);
    cmd_bus.odt = v;
  endtask
  // no read command is ever issued
endmodule // dxi_ctrl_model
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the ddr2 init tracker
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dxi_pkg::*;
  typedef struct packed {
    logic [3:0] rcw;
    logic [1:0] ba;
    logic [12:0] a;
  } dxi_row_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  dxi_cmd_bus_t cmd_bus;
  dxi_regs_t regs_q;
  dxi_regs_t exp = '0;
  logic dll_locked_q, ready_q, banks_idle_q, term_on_q, seq_err_q;
  logic [3:0] init_state_q;
  int num_errors = 0;
  int comparisons = 0;
  // init order: pre, emr2 hot, emr3, emr1, dll reset, pre, ref x2, mr, ocd
  dxi_row_t rows [11] = '{'{4'h2, 2'h0, 13'h0400}, '{4'h0, 2'h2, 13'h0080},
    '{4'h0, 2'h3, 13'h0000}, '{4'h0, 2'h1, 13'h0000},
    '{4'h0, 2'h0, 13'h0100}, '{4'h2, 2'h0, 13'h0400},
    '{4'h1, 2'h0, 13'h0000}, '{4'h1, 2'h0, 13'h0000},
    '{4'h0, 2'h0, 13'h0042}, '{4'h0, 2'h1, 13'h0380},
    '{4'h0, 2'h1, 13'h0004}};
  always #20 clk = ~clk;
  dxi_ctrl_model u_ctrl (.clk(clk), .cmd_bus(cmd_bus));
  dxi_ddr2_init DUT (.clk(clk), .rst_b(rst_b), .ce(ce), .cmd_bus(cmd_bus),
    .regs_q(regs_q), .dll_locked_q(dll_locked_q), .ready_q(ready_q),
    .banks_idle_q(banks_idle_q), .term_on_q(term_on_q),
    .seq_err_q(seq_err_q), .init_state_q(init_state_q));
  task automatic chk_regs(input dxi_regs_t got, input dxi_regs_t want);
    comparisons++;
    if (got !== want)
    begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic chk_val(input logic [3:0] got, input logic [3:0] want);
    comparisons++;
    if (got !== want)
    begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #(40 * 15000);
    num_errors++;
    final_report();
  end
  initial
  begin
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    chk_regs(regs_q, exp);
    chk_val({3'h0, banks_idle_q}, 4'h1);
    u_ctrl.power_up();
    foreach (rows[i])
    begin
      u_ctrl.cmd(rows[i].rcw, rows[i].ba, rows[i].a);
      if (rows[i].rcw == 4'h0)
        exp[51 - 13 * rows[i].ba -: 13] = rows[i].a;
      chk_regs(regs_q, exp);
      chk_val({3'h0, seq_err_q}, 4'h0);
    end
    chk_val({3'h0, ready_q}, 4'h0);
    repeat (179) @(negedge clk);
    chk_val({dll_locked_q, ready_q, 2'h0}, 4'h0);
    @(negedge clk);
    chk_val({dll_locked_q, ready_q, 2'h0}, 4'hC);
    chk_val(init_state_q, 4'hB);
    $display("test init sequence done");
    ce = 1'b0;
    u_ctrl.cmd(4'h0, 2'h2, 13'h0000);
    chk_regs(regs_q, exp);
    ce = 1'b1;
    u_ctrl.cmd(4'h0, 2'h2, 13'h0000);
    exp.emr2 = 13'h0000;
    chk_regs(regs_q, exp);
    u_ctrl.cmd(4'h3, 2'h0, 13'h0000);
    chk_val({3'h0, banks_idle_q}, 4'h0);
    u_ctrl.cmd(4'h2, 2'h0, 13'h0400);
    chk_val({3'h0, banks_idle_q}, 4'h1);
    $display("test reload and banks done");
    u_ctrl.odt_set(1'b1);
    repeat (2) @(negedge clk);
    chk_val({3'h0, term_on_q}, 4'h1);
    u_ctrl.odt_set(1'b0);
    repeat (2) @(negedge clk);
    chk_val({3'h0, term_on_q}, 4'h0);
    $display("test termination done");
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    exp = '0;
    chk_regs(regs_q, exp);
    chk_val(init_state_q, 4'h0);
    rst_b = 1'b1;
    u_ctrl.power_up();
    u_ctrl.cmd(4'h0, 2'h3, 13'h0000);
    chk_val({3'h0, seq_err_q}, 4'h1);
    $display("test out of order done");
    final_report();
  end
endmodule // tb_top
`default_nettype wire
